// ==== common/psirq_pkg.sv ====
// constants for the phy status summary and interrupt control block
// assumes a 32-bit axi4-lite register bus with word-aligned registers
package psirq_pkg;
  // printed offsets are register indices; byte address is four times the index
  localparam logic [7:0] PSIRQ_IDX_STATUS = 8'h10;
  localparam logic [7:0] PSIRQ_IDX_ICTRL = 8'h11;
  localparam logic [7:0] PSIRQ_IDX_EVENT = 8'h12;
  localparam logic [7:0] PSIRQ_IDX_BASIC = 8'h01;
  // status summary field positions
  localparam int PSIRQ_ST_LINK = 0;
  localparam int PSIRQ_ST_SPEED10 = 1;
  localparam int PSIRQ_ST_DUPLEX = 2;
  localparam int PSIRQ_ST_LOOP = 3;
  localparam int PSIRQ_ST_ANDONE = 4;
  localparam int PSIRQ_ST_JABBER = 5;
  // interrupt control field positions
  localparam int PSIRQ_IC_OE = 0;
  localparam int PSIRQ_IC_EN = 1;
  localparam int PSIRQ_IC_TEST = 2;
  // event status layout: flags at 14:8, enables at 6:0
  localparam int PSIRQ_EV_FLAG_LSB = 8;
  localparam int PSIRQ_EV_NUM = 7;
  // event numbers: 6 energy, 5 link, 4 speed, 3 duplex, 2 an done, 1 fcs, 0 rxerr
  localparam int PSIRQ_EV_ANDONE = 2;
  localparam int PSIRQ_EV_DUPLEX = 3;
  localparam int PSIRQ_EV_SPEED = 4;
  localparam int PSIRQ_EV_LINK = 5;
  // basic mode status positions (link bit 2, jabber bit 1)
  localparam int PSIRQ_BS_JABBER = 1;
  localparam int PSIRQ_BS_LINK = 2;
  // reset values
  localparam logic [2:0] PSIRQ_IC_RESET = 3'h0;
  localparam logic [6:0] PSIRQ_EV_RESET = 7'h00;
  // axi responses
  localparam logic [1:0] PSIRQ_RESP_OKAY = 2'h0;
  localparam logic [1:0] PSIRQ_RESP_SLVERR = 2'h2;
endpackage

// ==== rtl/psirq_top.sv ====
// phy status summary, interrupt control and event status over axi4-lite
// assumes phy state inputs come from logic on the same clock; the shared
// pin input passes a two-flop synchroniser before use
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
// Summary of operation
// RULE_01 - jabber bit 5, meaningful at 10 Mbps only
// RULE_02 - jabber mirrors basic status, summary read keeps it
// RULE_03 - bit 4 reports auto-negotiation complete, reset 0
// RULE_04 - bit 3 reflects loopback enable
// RULE_05 - bit 2 resolved duplex, 1 full
// RULE_06 - software trusts duplex/speed only with valid link
// RULE_07 - bit 1 speed, 1 is 10 Mbps
// RULE_08 - bit 0 link, summary read keeps it
// RULE_09 - control bits 15:3 reserved, read zero
// RULE_10 - test bit forces interrupt while set
// RULE_11 - event enable gates event interrupts
// RULE_12 - output enable picks pin irq or powerdown
// RULE_13 - seven kinds of interrupt sources supported
// RULE_14 - event flags set regardless of enables
// RULE_15 - event flags clear on event register read
// RULE_16 - pin irq from oe and test or events
module psirq_top
  import psirq_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // axi4-lite write address and data
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // phy state from the transceiver core
  input wire logic link_up,
  input wire logic jabber_seen,
  input wire logic an_complete,
  input wire logic loopback_on,
  input wire logic duplex_full,
  input wire logic speed_is_10,
  input wire logic energy_change,
  input wire logic fcs_half_full,
  input wire logic rxerr_half_full,
  // shared powerdown or interrupt pin
  input wire logic powerdown_or_irq_pin_i,
  output logic powerdown_or_irq_pin_o,
  output logic powerdown_or_irq_pin_oe,
  output logic powerdown_req
);

  // control register fields
  logic test_interrupt_force_r;
  logic event_interrupt_enable_r;
  logic irq_oe_r;
  // event enables and sticky flags
  logic [PSIRQ_EV_NUM-1:0] ev_en_r;
  logic [PSIRQ_EV_NUM-1:0] ev_flag_r;
  logic [PSIRQ_EV_NUM-1:0] ev_flag_nxt;
  // previous phy state for change detection
  logic link_q_r;
  logic duplex_q_r;
  logic speed_q_r;
  logic andone_q_r;
  // pin synchroniser, first flop feeds only the second
  logic pin_meta_r;
  logic pin_sync_r;
  // write channel capture, address and data may come in either order
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] aw_idx_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  // read channel
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // handshakes
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  // a write executes once both halves are held
  wire wr_go = aw_held_r && w_held_r && !bvalid_r;
  wire wr_ictrl = wr_go && (aw_idx_r == PSIRQ_IDX_ICTRL);
  wire wr_event = wr_go && (aw_idx_r == PSIRQ_IDX_EVENT);
  wire wr_known = wr_ictrl || wr_event || (aw_idx_r == PSIRQ_IDX_STATUS);
  wire [7:0] ar_idx = s_axi_araddr[9:2];
  wire ar_aligned = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr[31:10] == 22'h0);
  wire rd_event = ar_take && ar_aligned && (ar_idx == PSIRQ_IDX_EVENT);

  // status summary: live mirrors, so reading it clears nothing
  wire [15:0] status_word = {10'h000,
    jabber_seen,   // see RULE_01 // see RULE_02
    an_complete,   // see RULE_03
    loopback_on,   // see RULE_04
    duplex_full,   // see RULE_05
    speed_is_10,   // see RULE_07
    link_up};      // see RULE_08
  // reserved control bits read zero
  wire [15:0] ictrl_word = {13'h0000, test_interrupt_force_r,
    event_interrupt_enable_r, irq_oe_r}; // see RULE_09
  wire [15:0] event_word = {1'b0, ev_flag_r, 1'b0, ev_en_r};
  // read data select; unmapped aligned words read zero with slverr
  wire idx_status = ar_idx == PSIRQ_IDX_STATUS;
  wire idx_ictrl = ar_idx == PSIRQ_IDX_ICTRL;
  wire idx_event = ar_idx == PSIRQ_IDX_EVENT;
  wire rd_hit = ar_aligned && (idx_status || idx_ictrl || idx_event);
  wire [15:0] rd_word = !ar_aligned ? 16'h0000 :
                        idx_status ? status_word :
                        idx_ictrl ? ictrl_word :
                        idx_event ? event_word : 16'h0000;

  // raw events: link, speed, duplex strobe on a change, an done on a rise; energy, fcs, rxerr pass through
  wire [PSIRQ_EV_NUM-1:0] ev_hit;
  assign ev_hit[6] = energy_change;                    // see RULE_13
  assign ev_hit[PSIRQ_EV_LINK] = link_up ^ link_q_r;
  assign ev_hit[PSIRQ_EV_SPEED] = speed_is_10 ^ speed_q_r;
  assign ev_hit[PSIRQ_EV_DUPLEX] = duplex_full ^ duplex_q_r;
  assign ev_hit[PSIRQ_EV_ANDONE] = an_complete && !andone_q_r;
  assign ev_hit[1] = fcs_half_full;
  assign ev_hit[0] = rxerr_half_full;
  // flags set on event regardless of enable; a read clears, set wins
  assign ev_flag_nxt = (rd_event ? PSIRQ_EV_RESET : ev_flag_r) | ev_hit; // see RULE_14 // see RULE_15

  // interrupt request and pin direction
  wire ev_pending = |(ev_flag_r & ev_en_r);
  wire irq_req = test_interrupt_force_r || (event_interrupt_enable_r && ev_pending); // see RULE_10 // see RULE_11
  assign powerdown_or_irq_pin_oe = irq_oe_r;                   // see RULE_12
  assign powerdown_or_irq_pin_o = irq_oe_r && irq_req;         // see RULE_16
  assign powerdown_req = !irq_oe_r && pin_sync_r;              // see RULE_12

  // axi outputs
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // pin synchroniser
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
    end else begin
      pin_meta_r <= powerdown_or_irq_pin_i;
      pin_sync_r <= pin_meta_r;
    end
  end

  // previous phy state, loaded from reset zeros
  always_ff @(posedge clock) begin
    if (rst) begin
      link_q_r <= 1'b0;
      speed_q_r <= 1'b0;
      duplex_q_r <= 1'b0;
      andone_q_r <= 1'b0;
    end else begin
      link_q_r <= link_up;
      speed_q_r <= speed_is_10;
      duplex_q_r <= duplex_full;
      andone_q_r <= an_complete;
    end
  end

  // event flags
  always_ff @(posedge clock) begin
    if (rst) begin
      ev_flag_r <= PSIRQ_EV_RESET;
    end else begin
      ev_flag_r <= ev_flag_nxt;
    end
  end

  // write address and data capture
  always_ff @(posedge clock) begin
    if (rst) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_idx_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_held_r <= 1'b1;
        // misaligned or out-of-range addresses map to an unused index
        aw_idx_r <= (s_axi_awaddr[1:0] == 2'h0 && s_axi_awaddr[31:10] == 22'h0) ?
                    s_axi_awaddr[9:2] : 8'hff;
      end else if (wr_go) begin
        aw_held_r <= 1'b0;
      end
      if (w_take) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // register writes, only lane 0 carries live bits
  always_ff @(posedge clock) begin
    if (rst) begin
      {test_interrupt_force_r, event_interrupt_enable_r, irq_oe_r} <= PSIRQ_IC_RESET;
      ev_en_r <= PSIRQ_EV_RESET;
    end else begin
      if (wr_ictrl && wstrb_r[0]) begin
        test_interrupt_force_r <= wdata_r[PSIRQ_IC_TEST];
        event_interrupt_enable_r <= wdata_r[PSIRQ_IC_EN];
        irq_oe_r <= wdata_r[PSIRQ_IC_OE];
      end
      if (wr_event && wstrb_r[0]) begin
        ev_en_r <= wdata_r[PSIRQ_EV_NUM-1:0];
      end
    end
  end

  // write response
  always_ff @(posedge clock) begin
    if (rst) begin
      bvalid_r <= 1'b0;
      bresp_r <= PSIRQ_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_known ? PSIRQ_RESP_OKAY : PSIRQ_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // read response
  always_ff @(posedge clock) begin
    if (rst) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= PSIRQ_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= {16'h0000, rd_word};
      rresp_r <= rd_hit ? PSIRQ_RESP_OKAY : PSIRQ_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule

// ==== testbench/psirq_properties.sv ====
// checker for the status summary and interrupt control block
// assumes bind onto psirq_top, one clock, sync reset
`timescale 1ns/100ps
module psirq_properties
  import psirq_pkg::*;
(
  // clock and bus
  input wire logic clock,
  input wire logic rst,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  // phy state and pin
  input wire logic link_up,
  input wire logic jabber_seen,
  input wire logic an_complete,
  input wire logic loopback_on,
  input wire logic duplex_full,
  input wire logic speed_is_10,
  input wire logic powerdown_or_irq_pin_i,
  input wire logic powerdown_or_irq_pin_o,
  input wire logic powerdown_or_irq_pin_oe,
  input wire logic powerdown_req
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // marks a read in flight to the control word, so rdata can be judged
  logic ic_r;
  always_ff @(posedge clock) begin
    if (rst) ic_r <= 1'b0;
    else if (s_axi_arvalid && s_axi_arready) ic_r <= (s_axi_araddr == {22'h0, PSIRQ_IDX_ICTRL, 2'h0});
  end
  sequence s_st_rd;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == {22'h0, PSIRQ_IDX_STATUS, 2'h0};
  endsequence
  sequence s_ic_rv;
    s_axi_rvalid && ic_r;
  endsequence
  AST_ST_LOW:
    assert property (s_st_rd |=> s_axi_rdata[2:0] == $past({duplex_full, speed_is_10, link_up}))
    else $error("status low bits");
  AST_ST_HIGH:
    assert property (s_st_rd |=> s_axi_rdata[5:3] == $past({jabber_seen, an_complete, loopback_on}))
    else $error("status high bits");
  AST_IC_RSV:
    assert property (s_ic_rv |-> s_axi_rdata[31:3] == 29'h0) else $error("control reserved");
  AST_IC_OE:
    assert property (s_ic_rv |-> s_axi_rdata[0] == powerdown_or_irq_pin_oe) else $error("oe bit");
  AST_TEST:
    assert property ((s_ic_rv and (s_axi_rdata[2] && powerdown_or_irq_pin_oe)) |-> powerdown_or_irq_pin_o)
    else $error("test irq");
  AST_EN:
    assert property ((s_ic_rv and (s_axi_rdata[2:1] == 2'h0)) |-> !powerdown_or_irq_pin_o)
    else $error("event gate");
  AST_PIN:
    assert property (powerdown_or_irq_pin_o |-> powerdown_or_irq_pin_oe) else $error("pin drive");
  AST_PD:
    assert property (!powerdown_or_irq_pin_oe [*3] |-> powerdown_req == $past(powerdown_or_irq_pin_i, 2))
    else $error("powerdown sync");
  AST_PD_OFF:
    assert property (powerdown_or_irq_pin_oe |-> !powerdown_req) else $error("powerdown with oe");
endmodule
bind psirq_top psirq_properties psirq_properties_inst (.*);

// ==== testbench/psirq_pin_model.sv ====
// far side of the shared pin: an external powerdown driver
// assumes no pull on the pin, so the driver always sets a level
`timescale 1ns/100ps
module psirq_pin_model (
  // pin side
  input wire logic oe,
  input wire logic drv,
  input wire logic pd_lvl,
  output logic pin
);
  // block owns the wire while oe is high, else the powerdown driver does
  assign pin = oe ? drv : pd_lvl;
endmodule

// ==== testbench/psirq_tb.sv ====
// self-checking bench for the status summary and interrupt control block
// assumes a 40 MHz clock and synchronous active-high reset
`timescale 1ns/100ps
module psirq_tb;
  import psirq_pkg::*;
  localparam logic [31:0] A_ST = 32'(PSIRQ_IDX_STATUS) << 2;
  localparam logic [31:0] A_IC = 32'(PSIRQ_IDX_ICTRL) << 2;
  localparam logic [31:0] A_EV = 32'(PSIRQ_IDX_EVENT) << 2;
  localparam logic [1:0] OK = PSIRQ_RESP_OKAY;
  logic clock = 0, rst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, pd_lvl = 0;
  logic [31:0] awa = 0, wd = 0, ara = 0;
  logic [5:0] st = 0; // jabber, an done, loopback, duplex, speed10, link
  logic [2:0] stb = 0; // energy, fcs half, rxerr half strobes
  wire logic awr, wrd, bv, arr, rv, p_o, p_oe, pdr, pin;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  int failures = 0, num_checks = 0, cyc = 0;
  always #12.5 clock = ~clock;
  psirq_top psirq_top_inst (.clock(clock), .rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .link_up(st[0]),
    .speed_is_10(st[1]), .duplex_full(st[2]), .loopback_on(st[3]), .an_complete(st[4]),
    .jabber_seen(st[5]), .energy_change(stb[2]), .fcs_half_full(stb[1]),
    .rxerr_half_full(stb[0]), .powerdown_or_irq_pin_i(pin), .powerdown_or_irq_pin_o(p_o),
    .powerdown_or_irq_pin_oe(p_oe), .powerdown_req(pdr));
  psirq_pin_model psirq_pin_model_inst (.oe(p_oe), .drv(p_o), .pd_lvl(pd_lvl), .pin(pin));
  // one compare for every result, bits widened to a word
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // write: both halves offered together, each dropped once taken
  // track each half locally: the request registers only update after this time step
  task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
    logic aw_done;
    logic w_done;
    @(posedge clock);
    {awa, wd, awv, wv, br} <= {a, d, 3'h7};
    aw_done = 1'b0;
    w_done = 1'b0;
    while (!(aw_done && w_done)) begin
      @(posedge clock);
      if (!aw_done && awr) begin
        aw_done = 1'b1;
        awv <= 0;
      end
      if (!w_done && wrd) begin
        w_done = 1'b1;
        wv <= 0;
      end
    end
    while (!bv) @(posedge clock);
    br <= 0;
    chk("bresp", 32'(er), 32'(bresp));
  endtask
  // read and compare data and response
  task automatic rd(input logic [31:0] a, e, input logic [1:0] er);
    @(posedge clock);
    {ara, arv, rr} <= {a, 2'h3};
    @(posedge clock);
    while (!arr) @(posedge clock);
    arv <= 0;
    @(posedge clock);
    while (!rv) @(posedge clock);
    rr <= 0;
    chk("rdata", e, rdata);
    chk("rresp", 32'(er), 32'(rresp));
  endtask
  task automatic set_st(logic [5:0] v);
    @(posedge clock);
    st <= v;
  endtask
  task automatic t_reset();
    rd(A_IC, 32'h0, OK);
    rd(A_EV, 32'h0, OK);
    chk("oe", 0, 32'(p_oe));
  endtask
  // walk one status bit at a time; a second read shows nothing clears
  task automatic t_status();
    for (int i = 0; i < 6; i++) begin
      set_st(6'h01 << i);
      rd(A_ST, 32'h1 << i, OK);
      rd(A_ST, 32'h1 << i, OK);
    end
    wr(A_ST, 32'hffff, OK);
    rd(A_ST, 32'h20, OK);
    // speed and duplex are only trusted with link up and negotiation done
    set_st(6'h17);
    rd(A_ST, 32'h17, OK);
    set_st(6'h0);
    rd(A_ST - 32'h4, 32'h0, PSIRQ_RESP_SLVERR);
    wr(A_ST - 32'h4, 32'h0, PSIRQ_RESP_SLVERR);
  endtask
  task automatic t_ctrl();
    wr(A_IC, 32'hffffffff, OK);
    rd(A_IC, 32'h7, OK);
    chk("pin_o", 1, 32'(p_o));
    wr(A_IC, 32'h3, OK);
    chk("pin_o", 0, 32'(p_o));
  endtask
  // flags set with enables off, clear on read, then drive the pin
  task automatic t_events();
    rd(A_EV, 32'h3c00, OK);
    @(posedge clock);
    {st, stb} <= {6'h17, 3'h7};
    @(posedge clock);
    stb <= 0;
    chk("pin_o", 0, 32'(p_o));
    rd(A_EV, 32'h7f00, OK);
    rd(A_EV, 32'h0, OK);
    wr(A_EV, 32'h20, OK);
    wr(A_IC, 32'h1, OK);
    set_st(6'h16);
    repeat (2) @(posedge clock);
    chk("pin_o", 0, 32'(p_o));
    wr(A_IC, 32'h3, OK);
    @(posedge clock);
    chk("pin_o", 1, 32'(p_o));
    rd(A_EV, 32'h2020, OK);
    chk("pin_o", 0, 32'(p_o));
  endtask
  task automatic t_pd();
    wr(A_IC, 32'h0, OK);
    @(posedge clock);
    pd_lvl <= 1;
    repeat (4) @(posedge clock);
    chk("pd_req", 1, 32'(pdr));
    chk("oe", 0, 32'(p_oe));
    pd_lvl <= 0;
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // cut a hang short
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    repeat (2) @(posedge clock);
    rst <= 0;
    t_reset();
    t_status();
    t_ctrl();
    t_events();
    t_pd();
    wrap_up();
  end
endmodule
